/* src/aclre_pkg.sv */
package aclre_pkg;

  // table shape
  localparam int ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 7;
  localparam int WORD_SEL_W = 3;

  // word offsets inside one table entry (address = {entry, word})
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_REF_A = 3'h1;
  localparam logic [2:0] W_REF_B = 3'h2;
  localparam logic [2:0] W_ACTION = 3'h3;
  localparam logic [2:0] W_PROC = 3'h4;
  localparam logic [2:0] W_COUNTER = 3'h5;

  // control word fields
  localparam int CTL_CAT_LSB = 0;
  localparam int CTL_SEL_LSB = 2;
  localparam int CTL_SRC_SEL = 4;
  localparam int CTL_POLARITY = 5;
  localparam int CTL_PORT_MODE_LSB = 6;
  localparam int CTL_FLAG_EN = 8;
  localparam int CTL_PROTO_LSB = 16;

  // reference word B fields, layer 2 and layer 4 layouts
  localparam int REFB_MAC_HI_LSB = 0;
  localparam int REFB_ETYPE_LSB = 16;
  localparam int REFB_FLAG_LSB = 0;
  localparam int REFB_TCP_FLAG_MASK_LSB = 8;

  // action word fields in count mode
  localparam int ACT_COUNT_LSB = 0;
  localparam int ACT_TIME_UNIT = 11;
  localparam int ACT_ALGO = 12;

  // processing word fields
  localparam int PROC_MASK_LSB = 0;
  localparam int PROC_LINK_LSB = 16;

  localparam logic [31:0] WORD_RESET = 32'h0;

  typedef enum logic [1:0] {
    ACLRE_CAT_OFF,
    ACLRE_CAT_L2,
    ACLRE_CAT_L3,
    ACLRE_CAT_L4
  } aclre_category_t;

  // time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS = 1000;
  localparam int US_PER_MS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] US_DIV_LAST = 5'(CYC_PER_US - 1);
  localparam logic [9:0] MS_DIV_LAST = 10'(US_PER_MS - 1);

endpackage

/* src/aclre_evaluator.sv */
// Local design decisions: the address map and the plain strobed port.
module aclre_evaluator (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [aclre_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // parsed header from the ingress parser
  input wire logic i_pkt_valid,
  input wire logic [47:0] i_pkt_dst_mac,
  input wire logic [47:0] i_pkt_src_mac,
  input wire logic [15:0] i_pkt_ethertype,
  input wire logic i_pkt_is_ipv4,
  input wire logic [31:0] i_pkt_src_ip,
  input wire logic [31:0] i_pkt_dst_ip,
  input wire logic [7:0] i_pkt_protocol,
  input wire logic i_pkt_is_tcp,
  input wire logic i_pkt_is_udp,
  input wire logic [15:0] i_pkt_src_port,
  input wire logic [15:0] i_pkt_dst_port,
  input wire logic [31:0] i_pkt_tcp_seq,
  input wire logic [7:0] i_pkt_tcp_flags,
  // verdict, one cycle after the header
  output logic o_result_valid,
  output logic [aclre_pkg::ENTRIES-1:0] o_rule_match,
  output logic o_action_hit,
  output logic [aclre_pkg::IDX_W-1:0] o_action_index,
  // count-mode events, one pulse per entry
  output logic [aclre_pkg::ENTRIES-1:0] o_count_event
);

  localparam int N = aclre_pkg::ENTRIES;

  logic [31:0] ctl_q [N];
  logic [31:0] refa_q [N];
  logic [31:0] refb_q [N];
  logic [31:0] act_q [N];
  logic [31:0] proc_q [N];
  logic [10:0] cnt_q [N];
  logic armed_q [N];

  logic [4:0] us_div_q;
  logic [9:0] ms_div_q;
  logic us_tick;
  logic ms_tick;

  logic [31:0] rdata_q;
  logic valid_q;
  logic [N-1:0] match_q;
  logic hit_q;
  logic [3:0] index_q;
  logic [N-1:0] evt_q;

  // address decode
  wire logic [3:0] addr_entry = i_reg_addr[aclre_pkg::ADDR_W-1:aclre_pkg::WORD_SEL_W];
  wire logic [2:0] addr_word = i_reg_addr[aclre_pkg::WORD_SEL_W-1:0];

  // ---------------------------------------------------------------
  // table storage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int e = 0; e < N; e++) begin
        ctl_q[e] <= aclre_pkg::WORD_RESET;
        refa_q[e] <= aclre_pkg::WORD_RESET;
        refb_q[e] <= aclre_pkg::WORD_RESET;
        act_q[e] <= aclre_pkg::WORD_RESET;
        proc_q[e] <= aclre_pkg::WORD_RESET;
      end
    end else if (i_reg_wr) begin
      unique case (addr_word)
        aclre_pkg::W_CTRL: ctl_q[addr_entry] <= i_reg_wdata;
        aclre_pkg::W_REF_A: refa_q[addr_entry] <= i_reg_wdata;
        aclre_pkg::W_REF_B: refb_q[addr_entry] <= i_reg_wdata;
        aclre_pkg::W_ACTION: act_q[addr_entry] <= i_reg_wdata;
        aclre_pkg::W_PROC: proc_q[addr_entry] <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux; counter word shows live state, unmapped words read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (addr_word)
      aclre_pkg::W_CTRL: rd_mux = ctl_q[addr_entry];
      aclre_pkg::W_REF_A: rd_mux = refa_q[addr_entry];
      aclre_pkg::W_REF_B: rd_mux = refb_q[addr_entry];
      aclre_pkg::W_ACTION: rd_mux = act_q[addr_entry];
      aclre_pkg::W_PROC: rd_mux = proc_q[addr_entry];
      aclre_pkg::W_COUNTER: rd_mux = {20'h0, armed_q[addr_entry], cnt_q[addr_entry]};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0;
    end else if (i_reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // time base: microsecond enable from the core clock, millisecond from that
  assign us_tick = (us_div_q == aclre_pkg::US_DIV_LAST);
  assign ms_tick = us_tick && (ms_div_q == aclre_pkg::MS_DIV_LAST);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      us_div_q <= 5'h0;
      ms_div_q <= 10'h0;
    end else begin
      us_div_q <= us_tick ? 5'h0 : us_div_q + 5'h1;
      if (us_tick) begin
        ms_div_q <= ms_tick ? 10'h0 : ms_div_q + 10'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-entry matching and counters
  logic [N-1:0] rule_true;
  logic [N-1:0] count_hit;
  logic [N-1:0] count_evt_d;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_entry
      wire logic [1:0] category = ctl_q[g][aclre_pkg::CTL_CAT_LSB +: 2];
      wire logic [1:0] sel = ctl_q[g][aclre_pkg::CTL_SEL_LSB +: 2];
      wire logic use_src = ctl_q[g][aclre_pkg::CTL_SRC_SEL];
      wire logic polarity = ctl_q[g][aclre_pkg::CTL_POLARITY];
      wire logic [1:0] port_mode = ctl_q[g][aclre_pkg::CTL_PORT_MODE_LSB +: 2];
      wire logic flag_en = ctl_q[g][aclre_pkg::CTL_FLAG_EN];
      wire logic [7:0] proto_ref = ctl_q[g][aclre_pkg::CTL_PROTO_LSB +: 8];

      // layer 2: 48-bit MAC and 16-bit EtherType references
      wire logic [47:0] mac_ref = {refb_q[g][aclre_pkg::REFB_MAC_HI_LSB +: 16], refa_q[g]};
      wire logic [15:0] etype_ref = refb_q[g][aclre_pkg::REFB_ETYPE_LSB +: 16];
      wire logic [47:0] pkt_mac = use_src ? i_pkt_src_mac : i_pkt_dst_mac;
      wire logic mac_eq = (pkt_mac == mac_ref);
      wire logic etype_eq = (i_pkt_ethertype == etype_ref);
      logic l2_eq;
      always_comb begin
        unique case (sel)
          2'b01: l2_eq = mac_eq;
          2'b10: l2_eq = etype_eq;
          default: l2_eq = mac_eq && etype_eq;
        endcase
      end

      // layer 3: masked single address or exact pair
      wire logic [31:0] pkt_ip = use_src ? i_pkt_src_ip : i_pkt_dst_ip;
      wire logic ip_masked_eq = (((pkt_ip ^ refa_q[g]) & ~refb_q[g]) == 32'h0);
      wire logic ip_pair_eq = (i_pkt_src_ip == refa_q[g])
                           && (i_pkt_dst_ip == refb_q[g]);
      wire logic l3_valid = i_pkt_is_ipv4 && (sel == 2'b01 || sel == 2'b10);
      wire logic l3_eq = (sel == 2'b01) ? ip_masked_eq : ip_pair_eq;

      // layer 4: protocol, port range, sequence number, flags
      wire logic [15:0] max_port = refa_q[g][31:16];
      wire logic [15:0] min_port = refa_q[g][15:0];
      wire logic [31:0] seq_ref = refa_q[g];
      wire logic [15:0] pkt_port = use_src ? i_pkt_src_port : i_pkt_dst_port;
      wire logic in_range = (pkt_port >= min_port) && (pkt_port <= max_port);
      logic port_eq;
      always_comb begin
        unique case (port_mode)
          2'b00: port_eq = 1'b1;
          2'b01: port_eq = (pkt_port == max_port) || (pkt_port == min_port);
          2'b10: port_eq = in_range;
          2'b11: port_eq = !in_range;
        endcase
      end
      wire logic [7:0] tcp_flag_mask = refb_q[g][aclre_pkg::REFB_TCP_FLAG_MASK_LSB +: 8];
      wire logic [7:0] flag_ref = refb_q[g][aclre_pkg::REFB_FLAG_LSB +: 8];
      wire logic flag_ok = !flag_en || (((i_pkt_tcp_flags ^ flag_ref) & ~tcp_flag_mask) == 8'h0);
      logic l4_eq;
      logic l4_valid;
      always_comb begin
        unique case (sel)
          2'b00: begin
            l4_valid = i_pkt_is_ipv4;
            l4_eq = (i_pkt_protocol == proto_ref);
          end
          2'b01: begin
            l4_valid = i_pkt_is_ipv4 && i_pkt_is_tcp;
            l4_eq = port_eq && flag_ok;
          end
          2'b10: begin
            l4_valid = i_pkt_is_ipv4 && i_pkt_is_udp;
            l4_eq = port_eq;
          end
          2'b11: begin
            l4_valid = i_pkt_is_ipv4 && i_pkt_is_tcp;
            l4_eq = (i_pkt_tcp_seq == seq_ref) && flag_ok;
          end
        endcase
      end

      // category select; polarity applies to the selected comparison
      logic cmp_valid;
      logic cmp_eq;
      always_comb begin
        unique case (aclre_pkg::aclre_category_t'(category))
          aclre_pkg::ACLRE_CAT_OFF: begin
            cmp_valid = 1'b0;
            cmp_eq = 1'b0;
          end
          aclre_pkg::ACLRE_CAT_L2: begin
            cmp_valid = 1'b1;
            cmp_eq = l2_eq;
          end
          aclre_pkg::ACLRE_CAT_L3: begin
            cmp_valid = l3_valid;
            cmp_eq = l3_eq;
          end
          aclre_pkg::ACLRE_CAT_L4: begin
            cmp_valid = l4_valid;
            cmp_eq = l4_eq;
          end
        endcase
      end
      wire logic cmp_true = cmp_valid && (polarity ? cmp_eq : !cmp_eq);

      // count mode pairs this matching entry with the action entry of same index
      wire logic count_mode = (category == 2'b01) && (sel == 2'b00);
      wire logic [10:0] count_val = act_q[g][aclre_pkg::ACT_COUNT_LSB +: 11];
      wire logic algo_events = act_q[g][aclre_pkg::ACT_ALGO];
      wire logic unit_tick = act_q[g][aclre_pkg::ACT_TIME_UNIT] ? ms_tick : us_tick;
      wire logic act_write = i_reg_wr && (addr_entry == 4'(g))
                          && (addr_word == aclre_pkg::W_ACTION);

      // a count-mode entry drives no forwarding action
      assign rule_true[g] = cmp_true && !count_mode;
      assign count_hit[g] = i_pkt_valid && cmp_true && count_mode;

      always_comb begin
        count_evt_d[g] = 1'b0;
        if (count_mode && !act_write) begin
          if (!algo_events) begin
            count_evt_d[g] = !count_hit[g] && unit_tick && armed_q[g]
                             && (cnt_q[g] <= 11'h1);
          end else begin
            count_evt_d[g] = count_hit[g] && ((cnt_q[g] + 11'h1) >= count_val);
          end
        end
      end

      // rewriting the action word restarts the counter from its new count, or from zero when the new word sets ACT_ALGO
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_q[g] <= 11'h0;
          armed_q[g] <= 1'b0;
        end else if (!count_mode) begin
          cnt_q[g] <= 11'h0;
          armed_q[g] <= 1'b0;
        end else if (act_write) begin
          // the table word lands at this same edge, so take the new fields from the bus
          cnt_q[g] <= i_reg_wdata[aclre_pkg::ACT_ALGO] ? 11'h0
                    : i_reg_wdata[aclre_pkg::ACT_COUNT_LSB +: 11];
          armed_q[g] <= 1'b0;
        end else if (!algo_events) begin
          if (count_hit[g]) begin
            cnt_q[g] <= count_val;
            armed_q[g] <= 1'b1;
          end else if (unit_tick && armed_q[g]) begin
            if (cnt_q[g] <= 11'h1) begin
              cnt_q[g] <= 11'h0;
              armed_q[g] <= 1'b0;
            end else begin
              cnt_q[g] <= cnt_q[g] - 11'h1;
            end
          end
        end else if (count_hit[g]) begin
          cnt_q[g] <= count_evt_d[g] ? 11'h0 : cnt_q[g] + 11'h1;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // processing entries: AND of selected rules, then lowest action index wins
  logic [N-1:0] set_true;
  logic [N-1:0] action_req;
  logic best_hit;
  logic [3:0] best_index;

  generate
    for (g = 0; g < N; g++) begin : g_proc
      wire logic [N-1:0] sel_mask = proc_q[g][aclre_pkg::PROC_MASK_LSB +: N];
      // an empty mask selects nothing and never fires
      assign set_true[g] = (sel_mask != 16'h0) && ((rule_true & sel_mask) == sel_mask);
    end
  endgenerate

  always_comb begin
    action_req = '0;
    for (int p = 0; p < N; p++) begin
      if (set_true[p]) begin
        action_req[proc_q[p][aclre_pkg::PROC_LINK_LSB +: 4]] = 1'b1;
      end
    end
  end

  always_comb begin
    best_hit = 1'b0;
    best_index = 4'h0;
    for (int a = N - 1; a >= 0; a--) begin
      if (action_req[a]) begin
        best_hit = 1'b1;
        best_index = 4'(a);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valid_q <= 1'b0;
      match_q <= '0;
      hit_q <= 1'b0;
      index_q <= 4'h0;
    end else begin
      valid_q <= i_pkt_valid;
      match_q <= i_pkt_valid ? rule_true : '0;
      hit_q <= i_pkt_valid && best_hit;
      index_q <= i_pkt_valid ? best_index : 4'h0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_q <= '0;
    end else begin
      evt_q <= count_evt_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_result_valid = valid_q;
  assign o_rule_match = match_q;
  assign o_action_hit = hit_q;
  assign o_action_index = index_q;
  assign o_count_event = evt_q;

endmodule

/* tb/aclre_checker.sv */
module aclre_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [aclre_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // verdict side
  input wire logic i_pkt_valid,
  input wire logic o_result_valid,
  input wire logic [aclre_pkg::ENTRIES-1:0] o_rule_match,
  input wire logic o_action_hit,
  input wire logic [aclre_pkg::IDX_W-1:0] o_action_index,
  input wire logic [aclre_pkg::ENTRIES-1:0] o_count_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of written category/select; the table itself is out of sight here
  logic [15:0] never_q;
  logic [15:0] count_q;
  wire ctl_wr = i_reg_wr && i_reg_addr[2:0] == aclre_pkg::W_CTRL;
  wire [3:0] cs = i_reg_wdata[3:0];
  wire is_count = cs == 4'h1;
  wire is_never = cs[1:0] == 2'h0 || is_count || cs == 4'h2 || cs == 4'he;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      never_q <= 16'hffff;
      count_q <= 16'h0;
    end else if (ctl_wr) begin
      never_q[i_reg_addr[6:3]] <= is_never;
      count_q[i_reg_addr[6:3]] <= is_count;
    end
  end
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_verdict_next: assert property (i_pkt_valid |=> o_result_valid)
    else $error("verdict missing after header");
  a_verdict_quiet: assert property (!o_result_valid |-> !o_rule_match && !o_action_hit)
    else $error("verdict outputs busy while idle");
  a_index_idle: assert property (!o_action_hit |-> o_action_index == 4'h0)
    else $error("action index without hit");
  a_hit_has_match: assert property (o_action_hit |-> o_rule_match != 16'h0)
    else $error("action hit with no true rule");
  // past table is the one the header saw, even if a write lands at that edge
  a_never_true: assert property (o_result_valid |-> !(o_rule_match & $past(never_q)))
    else $error("disabled or reserved rule reported true");
  a_event_mode: assert property (o_count_event != 16'h0 |-> !(o_count_event & ~$past(count_q)))
    else $error("count event from entry not in count mode");
  a_ref_readback: assert property (
    i_reg_rd && $past(i_reg_wr) && i_reg_addr == $past(i_reg_addr) && i_reg_addr[2:0] == 3'h1
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("reference word read back wrong");
  a_reserved_read: assert property (i_reg_rd && i_reg_addr[2:0] > 3'h5 |=> o_reg_rdata == 32'h0)
    else $error("unmapped word read nonzero");
  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind aclre_evaluator aclre_checker aclre_checker_inst (
  .i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
  .i_pkt_valid, .o_result_valid, .o_rule_match, .o_action_hit, .o_action_index, .o_count_event
);

/* tb/aclre_parser_model.sv */
module aclre_parser_model (
  // clock
  input wire logic i_core_clk,
  // header request
  input wire logic i_go,
  input wire logic [258:0] i_hdr,
  // parsed header
  output logic o_pkt_valid,
  output logic [47:0] o_dmac,
  output logic [47:0] o_smac,
  output logic [15:0] o_etype,
  output logic o_ip4,
  output logic [31:0] o_sip,
  output logic [31:0] o_dip,
  output logic [7:0] o_proto,
  output logic o_tcp,
  output logic o_udp,
  output logic [15:0] o_sport,
  output logic [15:0] o_dport,
  output logic [31:0] o_seq,
  output logic [7:0] o_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // fields are stale outside the pulse; a walking pattern stops them looking held
  logic [258:0] junk_q = '0;
  always @(posedge i_core_clk) junk_q <= {junk_q[257:0], ~junk_q[258]};
  assign o_pkt_valid = i_go;
  assign {o_dmac, o_smac, o_etype, o_ip4, o_sip, o_dip, o_proto, o_tcp, o_udp, o_sport,
    o_dport, o_seq, o_flags} = i_go ? i_hdr : junk_q;
endmodule

/* tb/acl_matching_rule_evaluator_test.sv */
module acl_matching_rule_evaluator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic go = 1'b0, rd_d = 1'b0, ip4 = 1'b1, tcp = 1'b1, udp = 1'b0, eq;
  logic [6:0] i_reg_addr = 7'h0;
  logic [31:0] i_reg_wdata = 32'h0, sip, dip, seq;
  logic [258:0] hdr = '0;
  logic [47:0] dmac, smac;
  logic [15:0] et, sp = 16'h1000, dp = 16'h0050;
  logic [7:0] protocol_reference = 8'h06, fl = 8'h12;
  int seed = 32'h0334;
  int err_total = 0;
  int compares = 0;
  logic [36:0] pq[$];
  logic [31:0] rq[$];
  wire o_pkt_valid, o_ip4, o_tcp, o_udp, o_result_valid, o_action_hit;
  wire [47:0] o_dmac, o_smac;
  wire [31:0] o_sip, o_dip, o_seq, o_reg_rdata;
  wire [15:0] o_etype, o_sport, o_dport, o_rule_match, o_count_event;
  wire [7:0] o_proto, o_flags;
  wire [3:0] o_action_index;
  aclre_parser_model aclre_parser_model_inst (.i_core_clk, .i_go(go), .i_hdr(hdr), .o_pkt_valid,
    .o_dmac, .o_smac, .o_etype, .o_ip4, .o_sip, .o_dip, .o_proto, .o_tcp, .o_udp, .o_sport,
    .o_dport, .o_seq, .o_flags);
  aclre_evaluator aclre_evaluator_inst (
    .i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_pkt_valid(o_pkt_valid), .i_pkt_dst_mac(o_dmac), .i_pkt_src_mac(o_smac),
    .i_pkt_ethertype(o_etype), .i_pkt_is_ipv4(o_ip4), .i_pkt_src_ip(o_sip),
    .i_pkt_dst_ip(o_dip), .i_pkt_protocol(o_proto), .i_pkt_is_tcp(o_tcp), .i_pkt_is_udp(o_udp),
    .i_pkt_src_port(o_sport), .i_pkt_dst_port(o_dport), .i_pkt_tcp_seq(o_seq),
    .i_pkt_tcp_flags(o_flags), .o_result_valid, .o_rule_match, .o_action_hit,
    .o_action_index, .o_count_event);
  task chk(string n, logic [36:0] s, logic [36:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // every driver task starts at a rising edge and leaves one idle edge behind it
  task wr(logic [3:0] e, logic [2:0] w, logic [31:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= {e, w};
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task rd(logic [3:0] e, logic [2:0] w, logic [31:0] x);
    i_reg_rd <= 1'b1;
    i_reg_addr <= {e, w};
    rq.push_back(x);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task wrrd(logic [3:0] e, logic [2:0] w, logic [31:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= {e, w};
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    rd(e, w, d);
  endtask
  task send(logic [15:0] m, logic h, logic [3:0] ix, logic [15:0] ev);
    go <= 1'b1;
    hdr <= {dmac, smac, et, ip4, sip, dip, protocol_reference, tcp, udp, sp, dp, seq, fl};
    pq.push_back({ev, m, h, ix});
    @(posedge i_core_clk);
    go <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // rule under test sits in entry 0; processing entry 0 links it to action 3
  task try(logic [31:0] c, logic [31:0] a, logic [31:0] b, logic x);
    wr(4'h0, 3'h0, c);
    wr(4'h0, 3'h1, a);
    wr(4'h0, 3'h2, b);
    send({15'h0, x}, x, x ? 4'h3 : 4'h0, 16'h0);
  endtask
  task ev(int q, int w);
    int k;
    k = 0;
    repeat (q) begin
      @(negedge i_core_clk);
      if (o_count_event[4] !== 1'b0) k++;
    end
    chk("ev_quiet", 37'(k), 37'h0);
    if (w > 0) begin
      k = 0;
      while (k < w && o_count_event[4] !== 1'b1) begin
        @(negedge i_core_clk);
        k++;
      end
      chk("ev_seen", {36'h0, o_count_event[4]}, 37'h1);
    end
    @(posedge i_core_clk);
  endtask
  always @(posedge i_core_clk) rd_d <= i_reg_rd;
  always @(negedge i_core_clk) begin
    if (o_result_valid === 1'b1)
      chk("verdict", {o_count_event, o_rule_match, o_action_hit, o_action_index},
        pq.size() ? pq.pop_front() : '1);
    if (rd_d) chk("rdata", {5'h0, o_reg_rdata}, {5'h0, rq.pop_front()});
  end
  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (60000) @(posedge i_core_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    dmac = {16'($random(seed)), 32'($random(seed))};
    smac = ~dmac;
    et = 16'($random(seed));
    sip = $random(seed);
    dip = $random(seed);
    seq = $random(seed);
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    for (int w = 0; w < 8; w++) rd(4'h7, w[2:0], 32'h0);
    wr(4'h7, 3'h5, 32'hffffffff);
    wr(4'h7, 3'h6, 32'hffffffff);
    rd(4'h7, 3'h5, 32'h0);
    rd(4'h7, 3'h6, 32'h0);
    wrrd(4'h7, 3'h1, $random(seed));
    wrrd(4'h7, 3'h2, $random(seed));
    wr(4'h0, 3'h4, 32'h00030001);
    try(32'h0, 32'h0, 32'h0, 1'b0);
    for (int s = 1; s < 4; s++)
      for (int d = 0; d < 2; d++)
        for (int p = 0; p < 2; p++) begin
          eq = s == 2 || d == 0;
          try({26'h0, p[0], d[0], s[1:0], 2'h1}, dmac[31:0], {et, dmac[47:32]}, p[0] ~^ eq);
        end
    try(32'h2d, dmac[31:0], {~et, dmac[47:32]}, 1'b0);
    try(32'h25, dmac[31:0], {~et, dmac[47:32]}, 1'b1);
    try(32'h36, sip ^ 32'hff, 32'hff, 1'b1);
    try(32'h36, sip ^ 32'h100, 32'hff, 1'b0);
    try(32'h26, dip, 32'h0, 1'b1);
    try(32'h2a, sip, dip, 1'b1);
    try(32'h2a, dip, sip, 1'b0);
    try(32'h02, 32'h0, 32'h0, 1'b0);
    try(32'h0e, 32'h0, 32'h0, 1'b0);
    try(32'h00060023, 32'h0, 32'h0, 1'b1);
    try(32'h00110023, 32'h0, 32'h0, 1'b0);
    try(32'h67, {16'h0050, 16'h0001}, 32'h0, 1'b1);
    try(32'h67, {16'h0051, 16'h0001}, 32'h0, 1'b0);
    try(32'ha7, {16'h0060, 16'h0050}, 32'h0, 1'b1);
    try(32'ha7, {16'h0040, 16'h0030}, 32'h0, 1'b0);
    try(32'he7, {16'h0060, 16'h0040}, 32'h0, 1'b0);
    try(32'he7, {16'h0040, 16'h0030}, 32'h0, 1'b1);
    try(32'h27, 32'h0, 32'h0, 1'b1);
    try(32'hb7, {16'h1000, 16'h1000}, 32'h0, 1'b1);
    try(32'h2f, seq, 32'h0, 1'b1);
    try(32'h2f, seq ^ 32'h1, 32'h0, 1'b0);
    try(32'h0f, seq, 32'h0, 1'b0);
    try(32'h127, 32'h0, 32'h0012, 1'b1);
    try(32'h127, 32'h0, 32'h0013, 1'b0);
    try(32'h127, 32'h0, 32'h0113, 1'b1);
    try(32'h27, 32'h0, 32'h0013, 1'b1);
    try(32'h2b, 32'h0, 32'h0, 1'b0);
    tcp = 1'b0;
    udp = 1'b1;
    try(32'h6b, {16'h0050, 16'h0}, 32'h0, 1'b1);
    ip4 = 1'b0;
    try(32'h6b, {16'h0050, 16'h0}, 32'h0, 1'b0);
    ip4 = 1'b1;
    wr(4'h0, 3'h0, 32'h00060023);
    wr(4'h1, 3'h0, 32'h00060023);
    wr(4'h2, 3'h0, 32'h00110023);
    wr(4'h0, 3'h4, 32'h00050003);
    wr(4'h1, 3'h4, 32'h00020001);
    wr(4'h2, 3'h4, 32'h00010005);
    send(16'h0003, 1'b1, 4'h2, 16'h0);
    wr(4'h1, 3'h4, 32'h0);
    send(16'h0003, 1'b1, 4'h5, 16'h0);
    wr(4'h0, 3'h4, 32'h00050005);
    send(16'h0003, 1'b0, 4'h0, 16'h0);
    wr(4'h0, 3'h0, 32'h0);
    wr(4'h1, 3'h0, 32'h0);
    wr(4'h4, 3'h0, 32'h21);
    wr(4'h4, 3'h1, dmac[31:0]);
    wr(4'h4, 3'h2, {et, dmac[47:32]});
    wr(4'h4, 3'h3, 32'h1802);
    send(16'h0, 1'b0, 4'h0, 16'h0);
    send(16'h0, 1'b0, 4'h0, 16'h0010);
    send(16'h0, 1'b0, 4'h0, 16'h0);
    send(16'h0, 1'b0, 4'h0, 16'h0010);
    wr(4'h4, 3'h3, 32'h0003);
    send(16'h0, 1'b0, 4'h0, 16'h0);
    ev(35, 0);
    send(16'h0, 1'b0, 4'h0, 16'h0);
    ev(45, 40);
    rd(4'h4, 3'h5, 32'h0);
    wr(4'h4, 3'h3, 32'h0802);
    send(16'h0, 1'b0, 4'h0, 16'h0);
    ev(24000, 26500);
    wr(4'h4, 3'h0, 32'h0);
    send(16'h0, 1'b0, 4'h0, 16'h0);
    chk("pending", 37'(pq.size()), 37'h0);
    end_of_test();
  end
endmodule
